// ### hdl/flash_write_code_protection.sv
// Configuration word store with flash write and code protection checks
//
// Behaviour
// - Mode bit 13 set enables low-voltage programming; clear demands high voltage on the pin.
// - Clearing the low-voltage mode bit is ignored while a low-voltage session runs.
// - Unimplemented bits of both protection words, bits 13 to 1 of the code word too, read 1.
// - Protection bits only ever go active by writes; only a bulk erase or a reset releases them.
// - Boot size: enable high gives 0, else 111..011 give 512..8192 words, last 01FFh..1FFFh.
// - A boot size above half the user memory is taken as exactly half.
// - Code protect bit 0 set leaves flash unprotected, clear protects it.
// - Under code protection external writes are refused and external reads return zeros.
// - The CPU's own reads of program memory are never restricted.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module flash_write_code_protection (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // Avalon-MM slave
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Pins from the programming side
   input  wire logic        i_lv_session,
   input  wire logic        i_bulk_erase,
   // Mode outputs
   output logic             o_low_voltage_prog_enable,
   output logic             o_hv_entry_required,
   // CPU self-write check
   input  wire logic        i_self_wr_req,
   input  wire logic [15:0] i_self_wr_addr,
   output logic             o_self_wr_ack,
   output logic             o_self_wr_allow,
   // External programmer access
   input  wire logic        i_ext_rd,
   input  wire logic        i_ext_wr,
   input  wire logic [13:0] i_ext_flash_data,
   output logic      [13:0] o_ext_rd_data,
   output logic             o_ext_wr_allow,
   // CPU internal read path
   input  wire logic        i_cpu_rd,
   input  wire logic [13:0] i_cpu_flash_data,
   output logic      [13:0] o_cpu_rd_data
);
   fwcp_pkg::bus_state_t st_q, st_d;
   logic [31:0] rdata_q, rdata_d;
   logic [13:0] mem_q, mem_d;
   logic [13:0] code_q, code_d;
   logic [1:0]  sess_sync_q, erase_sync_q;
   logic        self_ack_q, self_ack_d;
   logic        self_allow_q, self_allow_d;
   logic [13:0] ext_rd_q, ext_rd_d;
   logic        ext_wr_q, ext_wr_d;
   logic [13:0] cpu_rd_q, cpu_rd_d;
   logic [15:0] boot_size;
   logic [15:0] boot_last;
   logic        acc_wr;
   logic        lv_session;
   logic        erase;
   logic        prot_active;

   // Readback with unimplemented bits forced high
   function automatic logic [13:0] readback(input logic [13:0] val, input logic [13:0] impl);
      readback = val | ~impl;
   endfunction

   assign lv_session  = sess_sync_q[1];
   assign erase       = erase_sync_q[1];
   assign prot_active = ~code_q[fwcp_pkg::BIT_PROT_N];
   assign acc_wr      = (st_q == fwcp_pkg::BUS_ACK) && i_avs_write;

   // Pins come from the programmer, outside our clock
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sess_sync_q  <= 2'h0;
         erase_sync_q <= 2'h0;
      end else begin
         sess_sync_q  <= {sess_sync_q[0], i_lv_session};
         erase_sync_q <= {erase_sync_q[0], i_bulk_erase};
      end
   end

   boot_block_decode u_boot (
      .i_clk_sys             (i_clk_sys),
      .i_rst                 (i_rst),
      .i_boot_block_enable_n (mem_q[fwcp_pkg::BIT_BB_EN_N]),
      .i_boot_block_size_sel (mem_q[fwcp_pkg::BIT_BB_SIZE +: 3]),
      .o_boot_size           (boot_size),
      .o_boot_last           (boot_last)
   );

   // Bus answer: one wait cycle, readdata prepared while waiting
   always_comb begin
      st_d    = st_q;
      rdata_d = rdata_q;
      unique case (st_q)
         fwcp_pkg::BUS_IDLE: begin
            if (i_avs_read || i_avs_write) begin
               st_d = fwcp_pkg::BUS_ACK;
            end
            rdata_d = 32'h0000_0000; // Unmapped reads answer zero
            unique case (i_avs_address)
               fwcp_pkg::OFS_MEM_PROT: begin
                  rdata_d[13:0] = readback(mem_q, fwcp_pkg::MEM_IMPL_MASK);
               end
               fwcp_pkg::OFS_CODE_PROT: begin
                  rdata_d[13:0] = readback(code_q, fwcp_pkg::CODE_MASK);
               end
               fwcp_pkg::OFS_STATUS: begin
                  rdata_d[fwcp_pkg::ST_LAST_LSB +: 16] = boot_last;
                  rdata_d[fwcp_pkg::ST_SIZE_LSB +: 14] = boot_size[13:0];
                  rdata_d[fwcp_pkg::ST_CODE_PROT]      = prot_active;
                  rdata_d[fwcp_pkg::ST_LV_SESS]        = lv_session;
               end
               default: begin
                  rdata_d = 32'h0000_0000;
               end
            endcase
         end
         fwcp_pkg::BUS_ACK: begin
            st_d = fwcp_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_q    <= fwcp_pkg::BUS_IDLE;
         rdata_q <= 32'h0000_0000;
      end else begin
         st_q    <= st_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (st_q != fwcp_pkg::BUS_ACK);
   assign o_avs_readdata    = rdata_q;

   // Config words: erase wins over a write in the same cycle
   always_comb begin
      mem_d = mem_q;
      code_d = code_q;
      if (erase) begin
         mem_d  = fwcp_pkg::WORD_ERASED;
         code_d = fwcp_pkg::WORD_ERASED;
      end else if (acc_wr && i_avs_address == fwcp_pkg::OFS_MEM_PROT) begin
         // Sticky bits can only be cleared, i.e. protection only switched on
         mem_d = ((mem_q & i_avs_writedata[13:0]) & fwcp_pkg::MEM_STICKY)
               | (i_avs_writedata[13:0] & ~fwcp_pkg::MEM_STICKY);
         if (lv_session && mem_q[fwcp_pkg::BIT_LV_PROG]) begin
            mem_d[fwcp_pkg::BIT_LV_PROG] = 1'b1;
         end
      end else if (acc_wr && i_avs_address == fwcp_pkg::OFS_CODE_PROT) begin
         code_d = code_q & i_avs_writedata[13:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         mem_q <= fwcp_pkg::WORD_ERASED;
         code_q <= fwcp_pkg::WORD_ERASED;
      end else begin
         mem_q <= mem_d;
         code_q <= code_d;
      end
   end

   // Programming entry mode follows bit 13 directly
   assign o_low_voltage_prog_enable = mem_q[fwcp_pkg::BIT_LV_PROG];
   assign o_hv_entry_required       = ~mem_q[fwcp_pkg::BIT_LV_PROG];

   // Region pick for self-writes; config space wins, then boot, then storage
   always_comb begin
      self_ack_d   = i_self_wr_req;
      self_allow_d = 1'b0;
      if (i_self_wr_req) begin
         if (i_self_wr_addr >= fwcp_pkg::CFG_SPACE) begin
            self_allow_d = mem_q[fwcp_pkg::BIT_WP_CFG];
         end else if (!mem_q[fwcp_pkg::BIT_BB_EN_N] && i_self_wr_addr < boot_size) begin
            self_allow_d = mem_q[fwcp_pkg::BIT_WP_BOOT];
         end else if (!mem_q[fwcp_pkg::BIT_AREA_EN_N]
                      && i_self_wr_addr >= fwcp_pkg::USER_WORDS - fwcp_pkg::AREA_WORDS
                      && i_self_wr_addr < fwcp_pkg::USER_WORDS) begin
            self_allow_d = mem_q[fwcp_pkg::BIT_WP_AREA];
         end else if (i_self_wr_addr < fwcp_pkg::USER_WORDS) begin
            self_allow_d = mem_q[fwcp_pkg::BIT_WP_APP];
         end
      end
   end

   // External path gated by code protect; CPU path never gated
   always_comb begin
      ext_rd_d = ext_rd_q;
      cpu_rd_d = cpu_rd_q;
      ext_wr_d = i_ext_wr && !prot_active;
      if (i_ext_rd) begin
         ext_rd_d = prot_active ? 14'h0000 : i_ext_flash_data;
      end
      if (i_cpu_rd) begin
         cpu_rd_d = i_cpu_flash_data;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         self_ack_q   <= 1'b0;
         self_allow_q <= 1'b0;
         ext_rd_q     <= 14'h0000;
         ext_wr_q     <= 1'b0;
         cpu_rd_q     <= 14'h0000;
      end else begin
         self_ack_q   <= self_ack_d;
         self_allow_q <= self_allow_d;
         ext_rd_q     <= ext_rd_d;
         ext_wr_q     <= ext_wr_d;
         cpu_rd_q     <= cpu_rd_d;
      end
   end

   assign o_self_wr_ack   = self_ack_q;
   assign o_self_wr_allow = self_allow_q;
   assign o_ext_rd_data   = ext_rd_q;
   assign o_ext_wr_allow  = ext_wr_q;
   assign o_cpu_rd_data   = cpu_rd_q;

   sequence s_mem_wr_mode_clear;
      acc_wr && i_avs_address == fwcp_pkg::OFS_MEM_PROT
         && !i_avs_writedata[fwcp_pkg::BIT_LV_PROG] && !erase;
   endsequence

   property p_entry_mode;
      @(posedge i_clk_sys) disable iff (i_rst)
      (s_mem_wr_mode_clear and (!lv_session))
         |=> (!o_low_voltage_prog_enable && o_hv_entry_required);
   endproperty
   a_entry_mode: assert property (p_entry_mode) else $error("mode bit clear not applied");

   property p_mode_hold;
      @(posedge i_clk_sys) disable iff (i_rst)
      (s_mem_wr_mode_clear and (lv_session && o_low_voltage_prog_enable))
         |=> o_low_voltage_prog_enable;
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode bit lost in session");

   property p_code_read_ones;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_avs_read && !o_avs_waitrequest && i_avs_address == fwcp_pkg::OFS_CODE_PROT)
         |-> (o_avs_readdata[13:1] == 13'h1FFF && o_avs_readdata[31:14] == 18'h00000);
   endproperty
   a_code_read_ones: assert property (p_code_read_ones) else $error("unused bits not one");

   property p_sticky;
      @(posedge i_clk_sys) disable iff (i_rst)
      !erase |=> (((mem_q & ~$past(mem_q) & fwcp_pkg::MEM_STICKY) == 14'h0000)
                  && !(code_q[0] && !$past(code_q[0])));
   endproperty
   a_sticky: assert property (p_sticky) else $error("protection released without erase");

   property p_ext_wr_block;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_ext_wr && !code_q[0]) |=> !o_ext_wr_allow;
   endproperty
   a_ext_wr_block: assert property (p_ext_wr_block) else $error("ext write not blocked");

   property p_ext_rd_zero;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_ext_rd && prot_active) |=> (o_ext_rd_data == 14'h0000);
   endproperty
   a_ext_rd_zero: assert property (p_ext_rd_zero) else $error("protected read not zero");

   property p_cfg_wp;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_self_wr_req && i_self_wr_addr >= fwcp_pkg::CFG_SPACE && !mem_q[fwcp_pkg::BIT_WP_CFG])
         |=> (o_self_wr_ack && !o_self_wr_allow);
   endproperty
   a_cfg_wp: assert property (p_cfg_wp) else $error("config self-write not blocked");

   property p_cpu_rd;
      @(posedge i_clk_sys) disable iff (i_rst)
      i_cpu_rd |=> (o_cpu_rd_data == $past(i_cpu_flash_data));
   endproperty
   a_cpu_rd: assert property (p_cpu_rd) else $error("cpu read altered");
endmodule

// ### include/fwcp_pkg.sv
// Constants for the flash write and code protection block
package fwcp_pkg;
   // Avalon byte offsets
   localparam logic [3:0]  OFS_MEM_PROT  = 4'h0;
   localparam logic [3:0]  OFS_CODE_PROT = 4'h4;
   localparam logic [3:0]  OFS_STATUS    = 4'h8;
   // Memory protection word fields
   localparam int          BIT_LV_PROG   = 13;
   localparam int          BIT_WP_AREA   = 11;
   localparam int          BIT_WP_CFG    = 9;
   localparam int          BIT_WP_BOOT   = 8;
   localparam int          BIT_WP_APP    = 7;
   localparam int          BIT_AREA_EN_N = 4;
   localparam int          BIT_BB_EN_N   = 3;
   localparam int          BIT_BB_SIZE   = 0;
   localparam logic [13:0] MEM_IMPL_MASK = 14'h2B9F;
   localparam logic [13:0] MEM_STICKY    = 14'h0B80;
   // Code protection word: only bit 0 lives
   localparam int          BIT_PROT_N    = 0;
   localparam logic [13:0] CODE_MASK     = 14'h0001;
   // Blank / bulk-erased value of both words
   localparam logic [13:0] WORD_ERASED   = 14'h3FFF;
   // Status word fields
   localparam int          ST_LAST_LSB   = 0;
   localparam int          ST_SIZE_LSB   = 16;
   localparam int          ST_CODE_PROT  = 30;
   localparam int          ST_LV_SESS    = 31;
   // Memory geometry in words
   localparam logic [15:0] USER_WORDS    = 16'h4000;
   localparam logic [15:0] AREA_WORDS    = 16'h0080;
   localparam logic [15:0] BOOT_MIN      = 16'h0200;
   localparam logic [15:0] BOOT_512      = 16'h0200;
   localparam logic [15:0] CFG_SPACE     = 16'h8000;
   localparam logic [2:0]  BB_SEL_MIN    = 3'h7;
   // Bus answer states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;
endpackage

// ### hdl/boot_block_decode.sv
// Boot block size and last address decoder
`timescale 1ns/1ps
module boot_block_decode (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_boot_block_enable_n,
   input  wire logic [2:0]  i_boot_block_size_sel,
   output logic      [15:0] o_boot_size,
   output logic      [15:0] o_boot_last
);
   logic [15:0] raw;
   logic [15:0] half;

   // Each step down in the field doubles the block, then clamp at half memory
   always_comb begin
      half = fwcp_pkg::USER_WORDS >> 1;
      raw  = fwcp_pkg::BOOT_MIN << (fwcp_pkg::BB_SEL_MIN - i_boot_block_size_sel);
      if (i_boot_block_enable_n) begin
         o_boot_size = 16'h0000;
      end else if (raw > half || raw == 16'h0000) begin
         o_boot_size = half;
      end else begin
         o_boot_size = raw;
      end
      o_boot_last = (o_boot_size == 16'h0000) ? 16'h0000 : o_boot_size - 16'h0001;
   end

   property p_boot_min;
      @(posedge i_clk_sys) disable iff (i_rst)
      (!i_boot_block_enable_n && i_boot_block_size_sel == 3'h7)
         |-> (o_boot_size == fwcp_pkg::BOOT_512 && o_boot_last == 16'h01FF);
   endproperty
   a_boot_min: assert property (p_boot_min) else $error("boot size for 111 wrong");

   property p_boot_half;
      @(posedge i_clk_sys) disable iff (i_rst)
      (!i_boot_block_enable_n && i_boot_block_size_sel <= 3'h3)
         |-> (o_boot_size == 16'h2000 && o_boot_last == 16'h1FFF);
   endproperty
   a_boot_half: assert property (p_boot_half) else $error("boot size not clamped to half");
endmodule

// ### test/ext_programmer_model.sv
// External programmer model: strobes, flash data, session and erase pins
`timescale 1ns/1ps
module ext_programmer_model (
   input  wire logic        i_clk_sys,
   input  wire logic [13:0] i_ext_rd_data,
   input  wire logic        i_ext_wr_allow,
   output logic             o_ext_rd,
   output logic             o_ext_wr,
   output logic      [13:0] o_flash_data,
   output logic             o_lv_session,
   output logic             o_bulk_erase
);
   // Idle pins at time zero
   initial begin
      o_ext_rd      = 1'b0;
      o_ext_wr      = 1'b0;
      o_flash_data  = 14'h0000;
      o_lv_session  = 1'b0;
      o_bulk_erase  = 1'b0;
   end

   // One read strobe; data line shows the inverse once released
   task automatic ext_read(input logic [13:0] d, output logic [13:0] q);
      @(posedge i_clk_sys);
      o_ext_rd     <= 1'b1;
      o_flash_data <= d;
      @(posedge i_clk_sys);
      o_ext_rd     <= 1'b0;
      o_flash_data <= ~d;
      @(posedge i_clk_sys);
      q = i_ext_rd_data;
   endtask

   // One write strobe, allow sampled the cycle after it drops
   task automatic ext_write(output logic allow);
      @(posedge i_clk_sys);
      o_ext_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_ext_wr <= 1'b0;
      @(posedge i_clk_sys);
      allow = i_ext_wr_allow;
   endtask

   // Pin levels held long enough to cross the two-stage sync
   task automatic set_pins(input logic sess, input logic erase);
      @(posedge i_clk_sys);
      o_lv_session  <= sess;
      o_bulk_erase  <= erase;
      repeat (4) @(posedge i_clk_sys);
   endtask
endmodule

// ### test/flash_write_code_protection_tb_top.sv
// Self-checking bench for the flash write and code protection block
`timescale 1ns/1ps
module flash_write_code_protection_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic        waitreq;
   logic        ext_rd, ext_wr, sess, erase, ext_allow;
   logic [13:0] fdata, ext_q;
   logic        sw_req = 1'b0;
   logic [15:0] sw_addr = 16'h0000;
   logic        sw_ack, sw_allow, lv_en, hv_req;
   logic        cpu_rd = 1'b0;
   logic [13:0] cpu_data = 14'h0000;
   logic [13:0] cpu_q;
   int          err_total = 0;
   int          compares = 0;
   logic [31:0] q;
   logic [13:0] q14;
   logic        a;
   // Boot rows: written word, expected size, expected last address
   logic [13:0] row_wd [8] = '{14'h3FF7, 14'h3FF6, 14'h3FF5, 14'h3FF4,
                               14'h3FF3, 14'h3FF2, 14'h3FF0, 14'h3FFF};
   logic [13:0] row_sz [8] = '{14'h0200, 14'h0400, 14'h0800, 14'h1000,
                               14'h2000, 14'h2000, 14'h2000, 14'h0000};
   logic [15:0] row_la [8] = '{16'h01FF, 16'h03FF, 16'h07FF, 16'h0FFF,
                               16'h1FFF, 16'h1FFF, 16'h1FFF, 16'h0000};

   // Free-running 50 MHz clock
   always #10 clk = ~clk;

   flash_write_code_protection dut_u (
      .i_clk_sys(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .i_lv_session(sess), .i_bulk_erase(erase),
      .o_low_voltage_prog_enable(lv_en), .o_hv_entry_required(hv_req),
      .i_self_wr_req(sw_req), .i_self_wr_addr(sw_addr), .o_self_wr_ack(sw_ack),
      .o_self_wr_allow(sw_allow), .i_ext_rd(ext_rd), .i_ext_wr(ext_wr),
      .i_ext_flash_data(fdata), .o_ext_rd_data(ext_q), .o_ext_wr_allow(ext_allow),
      .i_cpu_rd(cpu_rd), .i_cpu_flash_data(cpu_data), .o_cpu_rd_data(cpu_q));

   ext_programmer_model prog_u (
      .i_clk_sys(clk), .i_ext_rd_data(ext_q), .i_ext_wr_allow(ext_allow),
      .o_ext_rd(ext_rd), .o_ext_wr(ext_wr), .o_flash_data(fdata),
      .o_lv_session(sess), .o_bulk_erase(erase));

   // Compare with case inequality so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // Avalon access held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a_i, input logic [13:0] d);
      int n;
      @(posedge clk);
      rd    <= ~w;
      wr    <= w;
      addr  <= a_i;
      wdata <= {18'h00000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      // A hung slave ends the run at once
      if (n >= 50) begin
         chk(32'h1, 32'h0, "bus timeout");
         finish_test;
      end
   endtask

   // Self-write query; ack and allow sampled in the cycle they stand
   task automatic self_wr(input logic [15:0] ad, input logic exp);
      @(posedge clk);
      sw_req  <= 1'b1;
      sw_addr <= ad;
      @(posedge clk);
      sw_req <= 1'b0;
      @(posedge clk);
      chk({30'h0, sw_ack, sw_allow}, {30'h0, 1'b1, exp}, "self write");
   endtask

   task automatic finish_test;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      finish_test;
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 14'h0000); chk(q & 32'h3FFF, 32'h3FFF, "mem reset");
      bus(1'b0, 4'h4, 14'h0000); chk(q & 32'h3FFF, 32'h3FFF, "code word reset");
      chk({lv_en, hv_req}, 2'b10, "mode reset");
      // Boot size table through the status word
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 4'h0, row_wd[i]);
         bus(1'b0, 4'h8, 14'h0000);
         chk(q[29:16], row_sz[i], "boot size");
         if (row_sz[i] != 14'h0000) chk(q[15:0], row_la[i], "boot last");
      end
      // Third address falls in the unmapped gap, which always refuses
      foreach (row_la[i]) if (i < 3) self_wr(16'h0100 + 16'h3EC0 * i[15:0], i < 2);
      self_wr(16'h8000, 1'b1);
      // Protect boot, storage and config regions
      bus(1'b1, 4'h0, 14'h34E7);
      bus(1'b0, 4'h0, 14'h0000); chk(q & 32'h3FFF, 32'h34E7, "protect");
      self_wr(16'h0100, 1'b0);
      self_wr(16'h3FC0, 1'b0);
      self_wr(16'h8000, 1'b0);
      self_wr(16'h0300, 1'b1);
      bus(1'b1, 4'h0, 14'h3FFF);
      bus(1'b0, 4'h0, 14'h0000); chk(q & 32'h3FFF, 32'h34FF, "sticky");
      self_wr(16'h0100, 1'b1);
      self_wr(16'h3FC0, 1'b1);
      self_wr(16'h8000, 1'b0);
      // Mode bit outside and inside a low-voltage session
      bus(1'b1, 4'h0, 14'h1FFF);
      bus(1'b0, 4'h0, 14'h0000); chk(q & 32'h3FFF, 32'h14FF, "mode clear");
      chk({lv_en, hv_req}, 2'b01, "hv mode");
      bus(1'b1, 4'h0, 14'h3FFF);
      prog_u.set_pins(1'b1, 1'b0);
      bus(1'b1, 4'h0, 14'h1FFF);
      bus(1'b0, 4'h0, 14'h0000); chk(q & 32'h3FFF, 32'h34FF, "mode held");
      chk({lv_en, hv_req}, 2'b10, "low voltage mode");
      prog_u.set_pins(1'b0, 1'b0);
      // Code protection against the external programmer only
      prog_u.ext_read(14'h2A55, q14); chk(q14, 14'h2A55, "ext open");
      prog_u.ext_write(a); chk(a, 1'b1, "ext wr open");
      bus(1'b1, 4'h4, 14'h0000);
      bus(1'b0, 4'h4, 14'h0000); chk(q & 32'h3FFF, 32'h3FFE, "code word");
      bus(1'b0, 4'h8, 14'h0000); chk(q[31:30], 2'b01, "status flags");
      prog_u.ext_read(14'h2A55, q14); chk(q14, 14'h0000, "ext closed");
      prog_u.ext_write(a); chk(a, 1'b0, "ext wr closed");
      @(posedge clk);
      cpu_rd   <= 1'b1;
      cpu_data <= 14'h1234;
      @(posedge clk);
      cpu_rd <= 1'b0;
      @(posedge clk);
      chk(cpu_q, 14'h1234, "cpu read");
      bus(1'b0, 4'hC, 14'h0000); chk(q, 32'h0, "unmapped");
      // Bulk erase releases every protection
      prog_u.set_pins(1'b0, 1'b1);
      prog_u.set_pins(1'b0, 1'b0);
      bus(1'b0, 4'h0, 14'h0000); chk(q & 32'h3FFF, 32'h3FFF, "erase mem");
      bus(1'b0, 4'h4, 14'h0000); chk(q & 32'h3FFF, 32'h3FFF, "erase code word");
      prog_u.ext_read(14'h155A, q14); chk(q14, 14'h155A, "ext reopen");
      finish_test;
   end
endmodule
